/* File: pkg/kds_pkg.sv */
// Constants and types shared by the key/display scanner.
// Assumes a single 40 MHz clock domain and a synchronous reset.
package kds_pkg;

    // Matrix and display geometry
    localparam int NUM_COLS = 16;
    localparam int NUM_ROWS = 4;
    localparam int NUM_NUMERALS = 11;

    // Clock and scan timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCAN_RATE_HZ = 100;
    localparam int INSTR_TIME_NS = 10800;
    localparam int INSTR_PER_DIGIT = 60;
    // Longest dwell that still meets the scan rate, rounded down
    localparam int DWELL_CYCLES = CLK_HZ / (SCAN_RATE_HZ * NUM_COLS);
    // Per-digit budget of sixty instruction times, rounded down
    localparam int BUDGET_CYCLES = (INSTR_TIME_NS * INSTR_PER_DIGIT) / CLK_PERIOD_NS;

    // Probe slot length covers the two-stage row synchroniser
    localparam logic [15:0] PROBE_CYCLES = 16'h0004;
    // Consecutive equal scans needed to accept a key
    localparam logic [1:0] DEBOUNCE_SCANS = 2'h3;
    // Cycles allowed for the external nibble multiplexer to settle
    localparam logic [1:0] MUX_SETTLE = 2'h3;

    // Encoder codes
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_MULTI = 4'hF;

    // Reset, blank and numeral decode values
    localparam logic [15:0] STROBE_IDLE = 16'hFFFF;
    localparam logic [10:0] NUMERAL_OFF = 11'h000;
    localparam logic [10:0] NUMERAL_ALT = 11'h400;
    localparam logic [3:0] NUMERAL_MAX = 4'h9;

    typedef enum logic [2:0] {
        KDS_PROBE = 3'b001,
        KDS_SELECT = 3'b010,
        KDS_DWELL = 3'b100
    } kds_scan_state_t;

    typedef enum logic [3:0] {
        KDS_C_IDLE = 4'b0001,
        KDS_C_LOW = 4'b0010,
        KDS_C_HIGH = 4'b0100,
        KDS_C_RELEASE = 4'b1000
    } kds_char_state_t;

endpackage

/* File: rtl/kds_key_encode.sv */
// Position encoder for one column sample of the key matrix.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none

module kds_key_encode
(
    // Column sample, one bit per row, high = pressed
    input wire logic [3:0] sample,
    // Position code
    output logic [3:0] code
);

    always_comb
    begin
        case (sample)
            4'h0: code = kds_pkg::CODE_NONE;
            4'h1: code = 4'h1;
            4'h2: code = 4'h2;
            4'h4: code = 4'h3;
            4'h8: code = 4'h4;
            // Any two or more pressed keys are ambiguous
            default: code = kds_pkg::CODE_MULTI;
        endcase
    end

endmodule

`default_nettype wire

/* File: rtl/kds_scanner.sv */
// Key matrix and multiplexed numeral display scanner.
// Assumes row sense lines and the pre-encoded keyboard pins are asynchronous;
// digitValue comes from logic on the same clock and answers digitIndex.
`timescale 1ns/1ps
`default_nettype none

module kds_scanner
#(
    // Cycles per digit slot; shorten in simulation (at least 3)
    parameter int TICK_CYCLES = kds_pkg::DWELL_CYCLES
)
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Key matrix
    output logic [15:0] columnStrobeN,
    input wire logic [3:0] rowSenseN,
    // Display
    output logic [3:0] digitIndex,
    input wire logic [3:0] digitValue,
    output logic [10:0] numeralDrive,
    output logic [15:0] positionEnable,
    // Debounced key
    output logic keyValid,
    output logic [3:0] keyColumn,
    output logic [3:0] keyCode,
    // Pre-encoded keyboard
    input wire logic keyReady,
    input wire logic [3:0] keyNibble,
    output logic nibbleSelect,
    output logic charValid,
    output logic [7:0] charCode
);

    typedef struct packed {
        kds_pkg::kds_scan_state_t scanState;
        logic [3:0] scanIdx;
        logic [15:0] tickCnt;
        logic scanKeys;
        logic [15:0][3:0] lastCode;
        logic [15:0][1:0] hits;
        logic [15:0] reported;
        logic [15:0] strobeN;
        logic [10:0] numeral;
        logic [15:0] position;
        logic keyValid;
        logic [3:0] keyColumn;
        logic [3:0] keyCode;
        logic [3:0] rowsMeta;
        logic [3:0] rowsSync;
        logic readyMeta;
        logic readySync;
        logic [3:0] nibMeta;
        logic [3:0] nibSync;
        kds_pkg::kds_char_state_t charState;
        logic [1:0] waitCnt;
        logic [3:0] lowNib;
        logic muxSel;
        logic charValid;
        logic [7:0] charCode;
    } kds_state_t;

    kds_state_t state_reg;
    kds_state_t state_next;
    logic [3:0] encSample;
    logic [3:0] encCode;
    logic [15:0] tickReload;

    // Rows read low when pressed, so invert before encoding
    assign encSample = ~state_reg.rowsSync;
    assign tickReload = 16'(TICK_CYCLES - 1);

    kds_key_encode u_encode
    (
        .sample(encSample),
        .code(encCode)
    );

    always_comb
    begin
        state_next = state_reg;
        state_next.keyValid = 1'b0;
        state_next.charValid = 1'b0;

        // Two-stage synchronisers for everything that arrives on pins
        state_next.rowsMeta = rowSenseN;
        state_next.rowsSync = state_reg.rowsMeta;
        state_next.readyMeta = keyReady;
        state_next.readySync = state_reg.readyMeta;
        state_next.nibMeta = keyNibble;
        state_next.nibSync = state_reg.nibMeta;

        unique case (state_reg.scanState)
            kds_pkg::KDS_PROBE:
            begin
                // Display driver off: every column low, whole matrix visible
                state_next.strobeN = 16'h0000;
                state_next.position = 16'h0000;
                state_next.numeral = kds_pkg::NUMERAL_OFF;
                if (state_reg.tickCnt != 16'h0000)
                begin
                    state_next.tickCnt = state_reg.tickCnt - 16'h0001;
                end
                else
                begin
                    // Skip key testing when nothing is pressed or pending
                    state_next.scanKeys = (|encSample) || (|state_reg.lastCode);
                    if (!((|encSample) || (|state_reg.lastCode)))
                    begin
                        state_next.hits = '0;
                        state_next.reported = 16'h0000;
                    end
                    state_next.scanIdx = 4'h0;
                    state_next.scanState = kds_pkg::KDS_SELECT;
                end
            end
            kds_pkg::KDS_SELECT:
            begin
                // One counter picks both the key column and the digit
                state_next.strobeN = ~(16'h0001 << state_reg.scanIdx);
                state_next.position = 16'h0000;
                if (digitValue <= kds_pkg::NUMERAL_MAX)
                begin
                    state_next.numeral = 11'h001 << digitValue;
                end
                else
                begin
                    // Codes above nine light the eleventh line
                    state_next.numeral = kds_pkg::NUMERAL_ALT;
                end
                state_next.tickCnt = tickReload;
                state_next.scanState = kds_pkg::KDS_DWELL;
            end
            kds_pkg::KDS_DWELL:
            begin
                state_next.position = 16'h0001 << state_reg.scanIdx;
                if (state_reg.tickCnt != 16'h0000)
                begin
                    state_next.tickCnt = state_reg.tickCnt - 16'h0001;
                end
                else
                begin
                    state_next.position = 16'h0000;
                    // Rows have settled by the end of the slot; test this column
                    if (state_reg.scanKeys)
                    begin
                        if (encCode == state_reg.lastCode[state_reg.scanIdx])
                        begin
                            if (state_reg.hits[state_reg.scanIdx] != kds_pkg::DEBOUNCE_SCANS)
                            begin
                                state_next.hits[state_reg.scanIdx] =
                                    state_reg.hits[state_reg.scanIdx] + 2'h1;
                            end
                            if (state_reg.hits[state_reg.scanIdx] ==
                                kds_pkg::DEBOUNCE_SCANS - 2'h1 &&
                                encCode != kds_pkg::CODE_NONE &&
                                encCode != kds_pkg::CODE_MULTI &&
                                !state_reg.reported[state_reg.scanIdx])
                            begin
                                state_next.keyValid = 1'b1;
                                state_next.keyColumn = state_reg.scanIdx;
                                state_next.keyCode = encCode;
                                state_next.reported[state_reg.scanIdx] = 1'b1;
                            end
                        end
                        else
                        begin
                            // Any change restarts the count for this column
                            state_next.lastCode[state_reg.scanIdx] = encCode;
                            state_next.hits[state_reg.scanIdx] = 2'h1;
                            state_next.reported[state_reg.scanIdx] = 1'b0;
                        end
                    end
                    if (state_reg.scanIdx == 4'hF)
                    begin
                        state_next.scanIdx = 4'h0;
                        state_next.tickCnt = kds_pkg::PROBE_CYCLES - 16'h0001;
                        state_next.scanState = kds_pkg::KDS_PROBE;
                    end
                    else
                    begin
                        state_next.scanIdx = state_reg.scanIdx + 4'h1;
                        state_next.scanState = kds_pkg::KDS_SELECT;
                    end
                end
            end
        endcase

        // Pre-encoded keyboard: poll ready, then read both nibbles
        unique case (state_reg.charState)
            kds_pkg::KDS_C_IDLE:
            begin
                if (state_reg.readySync)
                begin
                    state_next.muxSel = 1'b0;
                    state_next.waitCnt = 2'h0;
                    state_next.charState = kds_pkg::KDS_C_LOW;
                end
            end
            kds_pkg::KDS_C_LOW:
            begin
                // Wait covers the mux settling plus the synchroniser
                if (state_reg.waitCnt != kds_pkg::MUX_SETTLE)
                begin
                    state_next.waitCnt = state_reg.waitCnt + 2'h1;
                end
                else
                begin
                    state_next.lowNib = state_reg.nibSync;
                    state_next.muxSel = 1'b1;
                    state_next.waitCnt = 2'h0;
                    state_next.charState = kds_pkg::KDS_C_HIGH;
                end
            end
            kds_pkg::KDS_C_HIGH:
            begin
                if (state_reg.waitCnt != kds_pkg::MUX_SETTLE)
                begin
                    state_next.waitCnt = state_reg.waitCnt + 2'h1;
                end
                else
                begin
                    state_next.charCode = {state_reg.nibSync, state_reg.lowNib};
                    state_next.charValid = 1'b1;
                    state_next.muxSel = 1'b0;
                    state_next.charState = kds_pkg::KDS_C_RELEASE;
                end
            end
            kds_pkg::KDS_C_RELEASE:
            begin
                // One character per ready pulse; a held ready is not re-read
                if (!state_reg.readySync)
                begin
                    state_next.charState = kds_pkg::KDS_C_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.scanState <= kds_pkg::KDS_PROBE;
            state_reg.tickCnt <= kds_pkg::PROBE_CYCLES - 16'h0001;
            state_reg.strobeN <= kds_pkg::STROBE_IDLE;
            state_reg.rowsMeta <= 4'hF;
            state_reg.rowsSync <= 4'hF;
            state_reg.charState <= kds_pkg::KDS_C_IDLE;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    assign columnStrobeN = state_reg.strobeN;
    assign digitIndex = state_reg.scanIdx;
    assign numeralDrive = state_reg.numeral;
    assign positionEnable = state_reg.position;
    assign keyValid = state_reg.keyValid;
    assign keyColumn = state_reg.keyColumn;
    assign keyCode = state_reg.keyCode;
    assign nibbleSelect = state_reg.muxSel;
    assign charValid = state_reg.charValid;
    assign charCode = state_reg.charCode;

    // Helper: length of the current position pulse in enabled cycles
    logic [15:0] dwellRun;
    always_ff @(posedge clk)
    begin
        if (reset || !(|state_reg.position))
        begin
            dwellRun <= 16'h0000;
        end
        else if (ce)
        begin
            dwellRun <= dwellRun + 16'h0001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_enc_idle: assert property (encSample == 4'h0 |-> encCode == 4'h0)
        else $error("Idle sample did not encode as zero");
    a_enc_multi: assert property ($countones(encSample) > 1 |-> encCode == 4'hF)
        else $error("Multiple keys did not encode as all ones");
    a_enc_single: assert property ($onehot(encSample) |->
        (encCode != 4'h0) && (encCode <= 4'h4) && encSample[encCode[1:0] - 2'h1])
        else $error("Single key encoded to wrong position");
    a_one_low: assert property (state_reg.scanState == kds_pkg::KDS_DWELL |->
        $onehot(~columnStrobeN) && !columnStrobeN[digitIndex])
        else $error("Dwell strobe is not a single low at the scan index");
    a_probe_low: assert property (state_reg.scanState == kds_pkg::KDS_PROBE &&
        state_reg.tickCnt != kds_pkg::PROBE_CYCLES - 16'h0001 |-> columnStrobeN == 16'h0000)
        else $error("Probe slot left a strobe high");
    a_num_first: assert property ($rose(|positionEnable) |->
        $stable(numeralDrive) && $past(state_reg.scanState, 2) == kds_pkg::KDS_SELECT)
        else $error("Position enabled before numeral was selected");
    a_col_advance: assert property (state_reg.scanState == kds_pkg::KDS_DWELL && ce &&
        state_reg.tickCnt == 16'h0000 && digitIndex != 4'hF
        |=> digitIndex == $past(digitIndex) + 4'h1)
        else $error("Scan index did not advance by one");
    a_key_debounce: assert property (keyValid |->
        state_reg.hits[keyColumn] == kds_pkg::DEBOUNCE_SCANS &&
        state_reg.lastCode[keyColumn] == keyCode)
        else $error("Key reported without enough equal scans");
    a_dwell_bound: assert property (dwellRun <= 16'(kds_pkg::BUDGET_CYCLES))
        else $error("Digit dwell exceeds the instruction budget");
    a_mux_high: assert property ($rose(charValid) |->
        $past(state_reg.charState) == kds_pkg::KDS_C_HIGH && $past(nibbleSelect))
        else $error("High nibble not read with mux select high");
    a_char_poll: assert property ($rose(nibbleSelect) |->
        $past(state_reg.charState) == kds_pkg::KDS_C_LOW)
        else $error("Character read without polling ready");

    c_key_accept: cover property (keyValid);
    c_char_read: cover property (charValid);
    c_ambiguous: cover property (state_reg.scanState == kds_pkg::KDS_DWELL &&
        encCode == 4'hF);
    c_scan_skip: cover property (state_reg.scanState == kds_pkg::KDS_SELECT &&
        !state_reg.scanKeys);

endmodule

`default_nettype wire

/* File: sim/kds_keypad_model.sv */
// Far side of the scanner: switch matrix, digit store and encoded keyboard.
// Assumes rows are pulled up and a pressed key shorts its column to its row.
`timescale 1ns/1ps
`default_nettype none

module kds_keypad_model
(
    // Key matrix
    input wire logic [15:0] columnStrobeN,
    output logic [3:0] rowSenseN,
    input wire logic [63:0] keysDown,
    // Display store
    input wire logic [3:0] digitIndex,
    output logic [3:0] digitValue,
    // Pre-encoded keyboard and nibble multiplexer
    input wire logic charReady,
    input wire logic [7:0] charByte,
    input wire logic nibbleSelect,
    output logic keyReady,
    output logic [3:0] keyNibble
);
    // A row reads low when any pressed key on it meets a low column
    always_comb
    begin
        rowSenseN = 4'hF;
        for (int c = 0; c < 16; c++)
            for (int r = 0; r < 4; r++)
                if (keysDown[c * 4 + r] && !columnStrobeN[c])
                    rowSenseN[r] = 1'b0;
    end

    // Values differ from the index so a swapped bus shows up
    assign digitValue = 4'hF - digitIndex;
    assign keyReady = charReady;
    assign keyNibble = nibbleSelect ? charByte[7:4] : charByte[3:0];
endmodule
`default_nettype wire

/* File: sim/keypad_display_scanner_bench.sv */
// Self-checking bench for the key/display scanner with a short digit slot.
// Assumes the far-side model answers combinationally.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp, msg) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("[ERR] %0t %s", $time, msg); \
        end \
    end

module keypad_display_scanner_bench;
    localparam int TICK = 8;
    localparam int SCAN = 4 + 16 * (TICK + 1);

    logic clk, reset, ce, keyReady, nibbleSelect, charValid, keyValid, charReady;
    logic [15:0] columnStrobeN, positionEnable;
    logic [3:0] rowSenseN, digitIndex, digitValue, keyColumn, keyCode, keyNibble;
    logic [10:0] numeralDrive;
    logic [7:0] charCode, charByte;
    logic [63:0] keysDown;
    logic [7:0] reports[$];
    int mismatches, checks, cyc, charCount;

    kds_scanner #(.TICK_CYCLES(TICK)) i_kds_scanner (.clk(clk), .reset(reset), .ce(ce),
        .columnStrobeN(columnStrobeN), .rowSenseN(rowSenseN), .digitIndex(digitIndex),
        .digitValue(digitValue), .numeralDrive(numeralDrive),
        .positionEnable(positionEnable), .keyValid(keyValid), .keyColumn(keyColumn),
        .keyCode(keyCode), .keyReady(keyReady), .keyNibble(keyNibble),
        .nibbleSelect(nibbleSelect), .charValid(charValid), .charCode(charCode));
    kds_keypad_model i_kds_keypad_model (.columnStrobeN(columnStrobeN),
        .rowSenseN(rowSenseN), .keysDown(keysDown), .digitIndex(digitIndex),
        .digitValue(digitValue), .charReady(charReady), .charByte(charByte),
        .nibbleSelect(nibbleSelect), .keyReady(keyReady), .keyNibble(keyNibble));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) cyc++;

    // Pulses are collected at the falling edge, where they are settled
    always @(negedge clk)
    begin
        if (keyValid === 1'b1)
            reports.push_back({keyColumn, keyCode});
        if (charValid === 1'b1)
            charCount++;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wait_strobe(input logic [15:0] pat);
        int n;
        n = 0;
        while (columnStrobeN !== pat && n < 2 * SCAN)
        begin
            @(negedge clk);
            n++;
        end
        `CHECK(columnStrobeN, pat, "strobe pattern not reached")
    endtask

    task automatic do_reset;
        reset = 1'b1;
        repeat (20) @(negedge clk);
        `CHECK({columnStrobeN, positionEnable}, {16'hFFFF, 16'h0000}, "reset outputs")
        `CHECK({keyValid, charCode, digitIndex}, {1'b0, 8'h00, 4'h0}, "reset state")
        reset = 1'b0;
        @(negedge clk);
        `CHECK(columnStrobeN, 16'h0000, "probe after reset")
        $display("test reset done");
    endtask

    task automatic test_encoder;
        logic [3:0] exp;
        logic hit;
        for (int i = 0; i < 16; i++)
        begin
            exp = 4'h0;
            for (int b = 0; b < 4; b++)
                if (i[b])
                    exp = 4'(b + 1);
            if ($countones(4'(i)) > 1)
                exp = 4'hF;
            // Each pattern sits on column 7 and reaches the encoder through the rows
            reports.delete();
            keysDown = 64'(i) << 28;
            repeat (5 * SCAN) @(negedge clk);
            hit = (reports.size() == 1) && (reports[0] == {4'h7, exp});
            // Idle and ambiguous codes are never handed out as keys
            if (exp == 4'h0 || exp == 4'hF)
                `CHECK(reports.size(), 0, "idle or ambiguous column reported")
            else
                `CHECK(hit, 1'b1, "encoder code")
            keysDown = 64'h0;
            repeat (2 * SCAN) @(negedge clk);
        end
        $display("test encoder done");
    endtask

    task automatic test_scan;
        int t0;
        logic [3:0] v;
        wait_strobe(~16'h0001);
        t0 = cyc;
        for (int n = 0; n < 16; n++)
        begin
            wait_strobe(~(16'h0001 << n));
            v = 4'hF - 4'(n);
            `CHECK(digitIndex, 4'(n), "digit index")
            `CHECK(numeralDrive, (v < 4'hA) ? (11'h001 << v) : 11'h400, "numeral")
            @(negedge clk);
            `CHECK(positionEnable, 16'h0001 << n, "position driver")
        end
        wait_strobe(16'h0000);
        // Frozen cycles must not advance the scan
        ce = 1'b0;
        repeat (10) @(negedge clk);
        `CHECK(columnStrobeN, 16'h0000, "strobe held while disabled")
        ce = 1'b1;
        wait_strobe(~16'h0001);
        `CHECK(cyc - t0, SCAN + 10, "full scan length")
        $display("test scan done");
    endtask

    task automatic wait_report;
        int n;
        n = 0;
        while (reports.size() == 0 && n < 5 * SCAN)
        begin
            @(negedge clk);
            n++;
        end
        `CHECK(reports.size() > 0, 1'b1, "no key report")
    endtask

    task automatic test_keys;
        logic [3:0] code;
        for (int r = 0; r < 4; r++)
        begin
            code = 4'(r + 1);
            reports.delete();
            keysDown = 64'h1 << (20 + r);
            repeat (2 * SCAN - 4) @(negedge clk);
            `CHECK(reports.size(), 0, "key accepted too early")
            wait_report();
            `CHECK(reports[0], {4'h5, code}, "single key report")
            repeat (2 * SCAN) @(negedge clk);
            `CHECK(reports.size(), 1, "held key reported again")
            keysDown = 64'h0;
            repeat (2 * SCAN) @(negedge clk);
        end
        $display("test keys done");
    endtask

    task automatic test_multi;
        reports.delete();
        // Two keys share column 2; two keys share row 1 across columns 3 and 9
        keysDown = (64'h3 << 8) | (64'h1 << 13) | (64'h1 << 37);
        repeat (6 * SCAN) @(negedge clk);
        `CHECK(reports.size(), 2, "report count with several keys")
        `CHECK(reports[0], 8'h32, "first key of shared row")
        `CHECK(reports[1], 8'h92, "second key of shared row")
        keysDown = 64'h0;
        repeat (2 * SCAN) @(negedge clk);
        $display("test multi done");
    endtask

    task automatic test_char(input logic [7:0] b);
        int n;
        charCount = 0;
        charByte = b;
        charReady = 1'b1;
        n = 0;
        while (charCount == 0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        `CHECK(charCode, b, "character code")
        `CHECK(nibbleSelect, 1'b0, "nibble select left high")
        repeat (30) @(negedge clk);
        `CHECK(charCount, 1, "character read once")
        charReady = 1'b0;
        repeat (6) @(negedge clk);
        $display("test char done");
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end

    initial
    begin
        reset = 1'b1;
        ce = 1'b1;
        keysDown = 64'h0;
        charReady = 1'b0;
        charByte = 8'h00;
        mismatches = 0;
        checks = 0;
        cyc = 0;
        charCount = 0;
        do_reset();
        test_encoder();
        test_scan();
        test_keys();
        test_multi();
        test_char(8'hA5);
        test_char(8'h3C);
        complete_run();
    end
endmodule
`default_nettype wire
